// [hw/pmac_port.v]
// Purpose: PHY-side data port toward an Ethernet MAC (GMII, MII, RGMII)
// Assumes: Link clocks are far slower than clk_sys; core side on clk_sys
// Notes:   Receive clocks are made here by a divider of clk_sys
// Operation
// - MII: transmit bits 7-4 ignored, pulled down
// - RGMII: transmit bits 7-4 ignored, pulled down
// - Transmit data accepted only with enable high
// - Transmit error marks bytes as errored
// - Error outside frame with the idle code byte requests low power idle
// - RGMII: separate transmit error ignored, pulled down
// - GMII uses MAC clock; MII pulls it down
// - MII: device drives transmit clock
// - GMII/MII: collision shown in half duplex
// - GMII/MII: carrier sense shown while carrier present
// - MII: receive bits 7-4 held low
// - Receive valid exactly while data presented
// - Receive error flags errored frame data
// - Receive error outside frame signals partner idle
// - RGMII: decode enable and error from control
// - RGMII: capture transmit data with MAC clock
// - RGMII: encode valid and error on control
// - RGMII: device drives receive clock per speed
`timescale 1ns/1ps
`default_nettype none
`include "pmac_consts.vh"

module pmac_port (
  input  wire       clk_sys,     // System clock, 20 MHz
  input  wire       rstn,        // Synchronous reset, active low
  input  wire [1:0] mode_sel,    // Interface mode
  input  wire [1:0] speed_sel,   // Link speed
  input  wire       full_duplex, // Duplex of the link
  input  wire       link_up,     // Link status
  input  wire [7:0] txd,         // Transmit data pins
  input  wire       tx_en,       // Transmit enable pin
  input  wire       tx_er,       // Transmit error pin
  input  wire       gtx_clk,     // Gigabit transmit clock pin
  input  wire       tx_ctl,      // RGMII transmit control pin
  input  wire       txc,         // RGMII transmit clock pin
  output wire       tx_clk,      // MII transmit clock pin
  output wire       txd_hi_pd,   // Pull-down on transmit bits 7-4
  output wire       tx_er_pd,    // Pull-down on transmit error
  output wire       gtx_clk_pd,  // Pull-down on gigabit clock
  output wire [7:0] rxd,         // Receive data pins
  output wire       rx_dv,       // Receive data valid pin
  output wire       rx_er,       // Receive error pin
  output wire       rx_ctl,      // RGMII receive control pin
  output wire       rx_clk,      // GMII/MII receive clock pin
  output wire       rxc,         // RGMII receive clock pin
  output wire       col,         // Collision pin
  output wire       crs,         // Carrier sense pin
  output wire [7:0] tx_data,     // Byte received from the MAC
  output wire       tx_valid,    // Byte strobe, one cycle
  output wire       tx_err,      // Byte carries an error
  output wire       tx_lpi,      // MAC requests low power idle
  input  wire [7:0] rx_data,     // Byte to send to the MAC
  input  wire       rx_valid,    // Byte offered
  input  wire       rx_err,      // Offered byte is errored
  input  wire       rx_lpi,      // Link partner in low power idle
  output wire       rx_ready,    // Byte taken this cycle
  input  wire       carrier,     // Carrier on the medium
  input  wire       collision    // Collision on the medium
);

  // ****************************************
  // Helper functions
  // ****************************************
  // Low power idle code: enable low, error high, code byte
  function is_lpi;
    input       en;
    input       er;
    input [7:0] d;
    begin
      is_lpi = !en && er && (d == `PMAC_LPI_CODE);
    end
  endfunction

  // Half period of the link clock for a speed
  function [7:0] half_of;
    input [1:0] spd;
    begin
      case (spd)
        `PMAC_SPD_1000: half_of = `PMAC_HALF_1000;
        `PMAC_SPD_100:  half_of = `PMAC_HALF_100;
        default:        half_of = `PMAC_HALF_10;
      endcase
    end
  endfunction

  // ****************************************
  // Declarations
  // ****************************************
  wire [`PMAC_SYNC_W-1:0] s_vec;
  wire [7:0]              s_txd;
  wire                    s_en;
  wire                    s_er;
  wire                    s_ctl;
  wire                    s_gtx;
  wire                    s_txc;
  wire                    m_gmii;
  wire                    m_mii;
  wire                    m_rgmii;
  wire [7:0]              txd_eff;
  wire                    er_eff;
  wire                    gtx_rise;
  wire                    txc_rise;
  wire                    txc_fall;
  wire [7:0]              half;
  wire                    wrap;
  wire                    clk_rise_evt;
  wire                    clk_fall_evt;
  wire                    clk_next;
  wire                    take_evt;
  wire [3:0]              status_nib;
  reg                     gtx_prev_q;
  reg                     txc_prev_q;
  reg  [7:0]              tx_data_q;
  reg                     tx_valid_q;
  reg                     tx_err_q;
  reg                     tx_lpi_q;
  reg  [3:0]              nib_q;
  reg                     nib_have_q;
  reg                     nib_err_q;
  reg  [3:0]              rg_lo_q;
  reg                     rg_en_q;
  reg  [7:0]              cnt_q;
  reg                     clk_q;
  reg                     tx_clk_q;
  reg                     rx_clk_q;
  reg                     rxc_q;
  reg  [7:0]              rxd_q;
  reg                     rx_dv_q;
  reg                     rx_er_q;
  reg                     rx_ctl_q;
  reg  [7:0]              hold_q;
  reg                     herr_q;
  reg                     phase_q;
  reg                     rg_dv_q;
  reg                     rg_er_q;
  reg                     col_q;
  reg                     crs_q;
  reg                     txd_hi_pd_q;
  reg                     tx_er_pd_q;
  reg                     gtx_clk_pd_q;

  // ****************************************
  // Pin synchronisation
  // ****************************************
  pmac_sync #(
    .WIDTH (`PMAC_SYNC_W)
  ) u_sync (
    .clk_sys  (clk_sys),
    .rstn     (rstn),
    .async_in ({txc, gtx_clk, tx_ctl, tx_er, tx_en, txd}),
    .sync_out (s_vec)
  );

  // Field split and mode decode
  assign s_txd   = s_vec[7:0];
  assign s_en    = s_vec[`PMAC_SB_EN];
  assign s_er    = s_vec[`PMAC_SB_ER];
  assign s_ctl   = s_vec[`PMAC_SB_CTL];
  assign s_gtx   = s_vec[`PMAC_SB_GTX];
  assign s_txc   = s_vec[`PMAC_SB_TXC];
  assign m_gmii  = (mode_sel == `PMAC_MODE_GMII);
  assign m_mii   = (mode_sel == `PMAC_MODE_MII);
  assign m_rgmii = (mode_sel == `PMAC_MODE_RGMII);

  // Unused upper bits and error pin masked per mode
  assign txd_eff = m_gmii ? s_txd : {4'h0, s_txd[3:0]};
  assign er_eff  = m_rgmii ? 1'b0 : s_er;

  // Edges of the MAC-made clocks
  assign gtx_rise = s_gtx && !gtx_prev_q;
  assign txc_rise = s_txc && !txc_prev_q;
  assign txc_fall = !s_txc && txc_prev_q;

  // ****************************************
  // Link clock divider
  // ****************************************
  assign half         = half_of(speed_sel);
  assign wrap         = (cnt_q >= (half - 8'h01));
  assign clk_rise_evt = wrap && !clk_q;
  assign clk_fall_evt = wrap && clk_q;
  assign clk_next     = wrap ? !clk_q : clk_q;

  // Divider and mode-gated clock outputs
  always @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      cnt_q    <= 8'h00;
      clk_q    <= 1'b0;
      tx_clk_q <= 1'b0;
      rx_clk_q <= 1'b0;
      rxc_q    <= 1'b0;
    end
    else
    begin
      cnt_q    <= wrap ? 8'h00 : cnt_q + 8'h01;
      clk_q    <= clk_next;
      tx_clk_q <= m_mii && clk_next;
      rx_clk_q <= (m_gmii || m_mii) && clk_next;
      rxc_q    <= m_rgmii && clk_next;
    end
  end

  // ****************************************
  // Transmit path
  // ****************************************
  always @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      gtx_prev_q <= 1'b0;
      txc_prev_q <= 1'b0;
      tx_data_q  <= 8'h00;
      tx_valid_q <= 1'b0;
      tx_err_q   <= 1'b0;
      tx_lpi_q   <= 1'b0;
      nib_q      <= 4'h0;
      nib_have_q <= 1'b0;
      nib_err_q  <= 1'b0;
      rg_lo_q    <= 4'h0;
      rg_en_q    <= 1'b0;
    end
    else
    begin
      gtx_prev_q <= s_gtx;
      txc_prev_q <= s_txc;
      tx_valid_q <= 1'b0;
      case (mode_sel)
        `PMAC_MODE_GMII:
        begin
          // Byte per rising edge of the MAC clock
          if (gtx_rise)
          begin
            if (s_en)
            begin
              tx_data_q  <= txd_eff;
              tx_valid_q <= 1'b1;
              tx_err_q   <= er_eff;
              tx_lpi_q   <= 1'b0;
            end
            else
            begin
              tx_lpi_q <= is_lpi(1'b0, er_eff, txd_eff);
            end
          end
        end
        `PMAC_MODE_MII:
        begin
          // Nibbles on own transmit clock, low nibble first
          if (clk_rise_evt)
          begin
            if (s_en)
            begin
              tx_lpi_q <= 1'b0;
              if (!nib_have_q)
              begin
                nib_q      <= txd_eff[3:0];
                nib_have_q <= 1'b1;
                nib_err_q  <= er_eff;
              end
              else
              begin
                tx_data_q  <= {txd_eff[3:0], nib_q};
                tx_valid_q <= 1'b1;
                tx_err_q   <= nib_err_q || er_eff;
                nib_have_q <= 1'b0;
              end
            end
            else
            begin
              nib_have_q <= 1'b0;
              tx_lpi_q   <= is_lpi(1'b0, er_eff, txd_eff);
            end
          end
        end
        `PMAC_MODE_RGMII:
        begin
          // Low nibble and enable on the rising edge
          if (txc_rise)
          begin
            rg_lo_q <= txd_eff[3:0];
            rg_en_q <= s_ctl;
          end
          // High nibble and enable xor error on the falling edge
          if (txc_fall)
          begin
            if (rg_en_q)
            begin
              tx_data_q  <= {txd_eff[3:0], rg_lo_q};
              tx_valid_q <= 1'b1;
              tx_err_q   <= rg_en_q ^ s_ctl;
              tx_lpi_q   <= 1'b0;
            end
            else
            begin
              tx_lpi_q <= is_lpi(1'b0, s_ctl, {txd_eff[3:0], rg_lo_q});
            end
          end
        end
        default:
        begin
          nib_have_q <= 1'b0;
          tx_lpi_q   <= 1'b0;
        end
      endcase
    end
  end

  // ****************************************
  // Receive path
  // ****************************************
  assign status_nib = {full_duplex, speed_sel, link_up};
  assign take_evt   = (m_gmii && clk_fall_evt) ||
                      (m_mii && clk_fall_evt && !phase_q) ||
                      (m_rgmii && clk_rise_evt);
  assign rx_ready   = take_evt;

  // Receive outputs updated on link clock moments
  always @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      rxd_q    <= 8'h00;
      rx_dv_q  <= 1'b0;
      rx_er_q  <= 1'b0;
      rx_ctl_q <= 1'b0;
      hold_q   <= 8'h00;
      herr_q   <= 1'b0;
      phase_q  <= 1'b0;
      rg_dv_q  <= 1'b0;
      rg_er_q  <= 1'b0;
    end
    else
    begin
      case (mode_sel)
        `PMAC_MODE_GMII:
        begin
          rx_ctl_q <= 1'b0;
          if (clk_fall_evt)
          begin
            if (rx_valid)
            begin
              rxd_q   <= rx_data;
              rx_dv_q <= 1'b1;
              rx_er_q <= rx_err;
            end
            else
            begin
              rxd_q   <= rx_lpi ? `PMAC_LPI_CODE : 8'h00;
              rx_dv_q <= 1'b0;
              rx_er_q <= rx_lpi;
            end
          end
        end
        `PMAC_MODE_MII:
        begin
          rx_ctl_q <= 1'b0;
          if (clk_fall_evt)
          begin
            if (phase_q)
            begin
              rxd_q   <= {4'h0, hold_q[7:4]};
              rx_er_q <= herr_q;
              phase_q <= 1'b0;
            end
            else if (rx_valid)
            begin
              rxd_q   <= {4'h0, rx_data[3:0]};
              rx_dv_q <= 1'b1;
              rx_er_q <= rx_err;
              hold_q  <= rx_data;
              herr_q  <= rx_err;
              phase_q <= 1'b1;
            end
            else
            begin
              rxd_q   <= rx_lpi ? (`PMAC_LPI_CODE & 8'h0F) : 8'h00;
              rx_dv_q <= 1'b0;
              rx_er_q <= rx_lpi;
            end
          end
        end
        `PMAC_MODE_RGMII:
        begin
          rx_dv_q <= 1'b0;
          rx_er_q <= 1'b0;
          // Rising edge: low nibble, control carries valid
          if (clk_rise_evt)
          begin
            if (rx_valid)
            begin
              rxd_q    <= {4'h0, rx_data[3:0]};
              rx_ctl_q <= 1'b1;
              hold_q   <= rx_data;
              rg_dv_q  <= 1'b1;
              rg_er_q  <= rx_err;
            end
            else if (rx_lpi)
            begin
              rxd_q    <= `PMAC_LPI_CODE & 8'h0F;
              rx_ctl_q <= 1'b0;
              hold_q   <= `PMAC_LPI_CODE;
              rg_dv_q  <= 1'b0;
              rg_er_q  <= 1'b1;
            end
            else
            begin
              rxd_q    <= {4'h0, status_nib};
              rx_ctl_q <= 1'b0;
              hold_q   <= {status_nib, status_nib};
              rg_dv_q  <= 1'b0;
              rg_er_q  <= 1'b0;
            end
          end
          // Falling edge: high nibble, control carries valid xor error
          if (clk_fall_evt)
          begin
            rxd_q    <= {4'h0, hold_q[7:4]};
            rx_ctl_q <= rg_dv_q ^ rg_er_q;
          end
        end
        default:
        begin
          rxd_q    <= 8'h00;
          rx_dv_q  <= 1'b0;
          rx_er_q  <= 1'b0;
          rx_ctl_q <= 1'b0;
          phase_q  <= 1'b0;
        end
      endcase
    end
  end

  // ****************************************
  // Half duplex indications and pull-downs
  // ****************************************
  always @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      col_q        <= 1'b0;
      crs_q        <= 1'b0;
      txd_hi_pd_q  <= 1'b0;
      tx_er_pd_q   <= 1'b0;
      gtx_clk_pd_q <= 1'b0;
    end
    else
    begin
      col_q        <= !m_rgmii && collision && !full_duplex;
      crs_q        <= !m_rgmii && carrier;
      txd_hi_pd_q  <= m_mii || m_rgmii;
      tx_er_pd_q   <= m_rgmii;
      gtx_clk_pd_q <= m_mii;
    end
  end

  // Output wiring
  assign tx_clk     = tx_clk_q;
  assign rx_clk     = rx_clk_q;
  assign rxc        = rxc_q;
  assign rxd        = rxd_q;
  assign rx_dv      = rx_dv_q;
  assign rx_er      = rx_er_q;
  assign rx_ctl     = rx_ctl_q;
  assign col        = col_q;
  assign crs        = crs_q;
  assign txd_hi_pd  = txd_hi_pd_q;
  assign tx_er_pd   = tx_er_pd_q;
  assign gtx_clk_pd = gtx_clk_pd_q;
  assign tx_data    = tx_data_q;
  assign tx_valid   = tx_valid_q;
  assign tx_err     = tx_err_q;
  assign tx_lpi     = tx_lpi_q;

endmodule // pmac_port

`default_nettype wire

// [hw/pmac_consts.vh]
// Purpose: Shared constants for the MAC-facing data port
// Assumes: Included by bare name from the design files
// Notes:   Link clock half periods are counts of clk_sys cycles
`ifndef PMAC_CONSTS_VH
`define PMAC_CONSTS_VH

// ****************************************
// Interface modes and link speeds
// ****************************************
`define PMAC_MODE_GMII   2'h0
`define PMAC_MODE_MII    2'h1
`define PMAC_MODE_RGMII  2'h2
`define PMAC_SPD_10      2'h0
`define PMAC_SPD_100     2'h1
`define PMAC_SPD_1000    2'h2

// ****************************************
// Link clock half periods in clk_sys cycles
// ****************************************
`define PMAC_HALF_1000   8'h04
`define PMAC_HALF_100    8'h14
`define PMAC_HALF_10     8'hC8

// ****************************************
// Line codes and synchroniser layout
// ****************************************
`define PMAC_LPI_CODE    8'h01
`define PMAC_SYNC_W      13
`define PMAC_SB_EN       8
`define PMAC_SB_ER       9
`define PMAC_SB_CTL      10
`define PMAC_SB_GTX      11
`define PMAC_SB_TXC      12

`endif

// [hw/pmac_sync.v]
// Purpose: Two flip-flop synchroniser for the MAC transmit pins
// Assumes: Inputs are asynchronous to clk_sys
// Notes:   Only the second stage leaves this module
`timescale 1ns/1ps
`default_nettype none

module pmac_sync #(
  parameter WIDTH = 13
) (
  input  wire             clk_sys,  // System clock
  input  wire             rstn,     // Synchronous reset, active low
  input  wire [WIDTH-1:0] async_in, // Pins from the MAC
  output wire [WIDTH-1:0] sync_out  // Synchronised copy
);

  reg [WIDTH-1:0] meta_q;
  reg [WIDTH-1:0] sync_q;

  // ****************************************
  // Two stage capture
  // ****************************************
  always @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      meta_q <= {WIDTH{1'b0}};
      sync_q <= {WIDTH{1'b0}};
    end
    else
    begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;

endmodule // pmac_sync

`default_nettype wire

// [dv/pmac_port_asserts.sv]
// Purpose: Port checker for the MAC-facing data port
// Assumes: Mode and speed change only under reset
// Notes:   Bound into every instance of the port
`timescale 1ns/1ps
`default_nettype none

module pmac_port_asserts (
  input wire logic       clk_sys,     // System clock
  input wire logic       rstn,        // Reset, active low
  input wire logic [1:0] mode_sel,    // Interface mode
  input wire logic [1:0] speed_sel,   // Link speed
  input wire logic       full_duplex, // Duplex
  input wire logic       carrier,     // Carrier in
  input wire logic       collision,   // Collision in
  input wire logic       rx_valid,    // Byte offered
  input wire logic       rx_lpi,      // Partner idle
  input wire logic       rx_ready,    // Byte taken
  input wire logic [7:0] rxd,         // Receive data
  input wire logic       rx_dv,       // Receive valid
  input wire logic       rx_er,       // Receive error
  input wire logic       rx_clk,      // Receive clock
  input wire logic       txd_hi_pd,   // Pull-down flag
  input wire logic       tx_er_pd,    // Pull-down flag
  input wire logic       gtx_clk_pd,  // Pull-down flag
  input wire logic       tx_valid,    // Byte strobe
  input wire logic       tx_err,      // Byte errored
  input wire logic       col,         // Collision out
  input wire logic       crs          // Carrier out
);
  // ****************************************
  // Port relations
  // ****************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  a_col_half: assert property ($past(rstn) && collision && !full_duplex && mode_sel < 2'h2 |=> col)
    else $error("collision not shown");
  a_col_full: assert property (full_duplex |=> !col)
    else $error("collision shown in full duplex");
  a_crs_follow: assert property ($past(rstn) && mode_sel < 2'h2 |=> crs == $past(carrier))
    else $error("carrier sense wrong");
  a_pd_flags: assert property ($past(rstn) |=> {txd_hi_pd, tx_er_pd, gtx_clk_pd} ==
    {$past(mode_sel) == 2'h1 || $past(mode_sel) == 2'h2, $past(mode_sel) == 2'h2,
     $past(mode_sel) == 2'h1})
    else $error("pull-down flags wrong");
  a_mii_rxhi: assert property ((mode_sel == 2'h1) [*2] |-> rxd[7:4] == 4'h0)
    else $error("upper receive bits driven");
  a_rgmii_quiet: assert property ($past(rstn) && mode_sel == 2'h2 |=> !rx_clk && !rx_dv && !rx_er)
    else $error("gmii receive pins active");
  a_txv_pulse: assert property (tx_valid |=> !tx_valid)
    else $error("byte strobe too long");
  a_rxdv_take: assert property ($rose(rx_dv) |-> $past(rx_ready && rx_valid))
    else $error("valid without a byte");
  a_lpi_idle: assert property ((mode_sel == 2'h0 && speed_sel == 2'h2 && rx_lpi && !rx_valid) [*8]
    |=> rx_er && !rx_dv && rxd == 8'h01)
    else $error("idle code missing");

  // Main scenarios reached
  c_tx_err: cover property (tx_valid && tx_err);
  c_rx_byte: cover property ($rose(rx_dv));
  c_col: cover property (col && crs);
endmodule // pmac_port_asserts

bind pmac_port pmac_port_asserts pmac_port_asserts_inst (.clk_sys, .rstn, .mode_sel,
  .speed_sel, .full_duplex, .carrier, .collision, .rx_valid, .rx_lpi, .rx_ready, .rxd,
  .rx_dv, .rx_er, .rx_clk, .txd_hi_pd, .tx_er_pd, .gtx_clk_pd, .tx_valid, .tx_err, .col, .crs);

`default_nettype wire

// [dv/pmac_mac_model.sv]
// Purpose: Behavioural MAC driving the transmit pins
// Assumes: Link clock period 400 ns, stopped between frames
// Notes:   Released data lines show the inverse of the last value
`timescale 1ns/1ps
`default_nettype none

module pmac_mac_model (
  input  wire logic       tx_clk,  // MII clock from the port
  output var  logic [7:0] txd,     // Transmit data
  output var  logic       tx_en,   // Transmit enable
  output var  logic       tx_er,   // Transmit error
  output var  logic       gtx_clk, // Gigabit clock
  output var  logic       tx_ctl,  // RGMII control
  output var  logic       txc      // RGMII clock
);
  // ****************************************
  // Pin drivers
  // ****************************************
  // Idle pins, error held low
  initial
  begin
    {txd, tx_en, tx_er, gtx_clk, tx_ctl, txc} = 13'h0000;
  end

  // One GMII beat, clock from the MAC
  task gmii_beat(input logic [7:0] d, input logic en, input logic er);
    txd = d;
    tx_en = en;
    tx_er = er;
    #200 gtx_clk = 1;
    #200 gtx_clk = 0;
  endtask

  // One MII byte, low nibble first, upper bits junk
  task mii_byte(input logic [7:0] d);
    @(negedge tx_clk) #25 txd = {4'hF, d[3:0]};
    tx_en = 1;
    @(negedge tx_clk) #25 txd = {4'hF, d[7:4]};
    @(negedge tx_clk) #25 tx_en = 0;
  endtask

  // One RGMII byte on both edges, separate error pin junk
  task rgmii_byte(input logic [7:0] d, input logic er);
    txd = {4'hA, d[3:0]};
    tx_ctl = 1;
    tx_er = 1;
    #100 txc = 1;
    #100 txd[3:0] = d[7:4];
    tx_ctl = 1 ^ er;
    #100 txc = 0;
    #100;
  endtask

  // Release after a frame
  task release_pins();
    txd = ~txd;
    tx_en = 0;
    tx_er = 0;
    tx_ctl = 0;
  endtask
endmodule // pmac_mac_model

`default_nettype wire

// [dv/pmac_port_test.sv]
// Purpose: Self-checking bench for the MAC-facing data port
// Assumes: Inputs change at the falling clock edge
// Notes:   Each scenario resets into its mode first
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_mismatch++; \
  $display("CHECK FAILED t=%0t got %0h exp %0h", $time, g, e); end end

module pmac_port_test;
  // ****************************************
  // Signals and instances
  // ****************************************
  logic       clk_sys = 0;
  logic       rstn = 0;
  logic [1:0] mode_sel = 2'h0;
  logic [1:0] speed_sel = 2'h2;
  logic       full_duplex = 0, link_up = 0, rx_valid = 0, rx_err = 0, rx_lpi = 0;
  logic       carrier = 0, collision = 0;
  logic [7:0] rx_data = 8'h00;
  wire  [7:0] txd, rxd, tx_data;
  wire        tx_en, tx_er, gtx_clk, tx_ctl, txc, tx_clk, txd_hi_pd, tx_er_pd, gtx_clk_pd;
  wire        rx_dv, rx_er, rx_ctl, rx_clk, rxc, col, crs, tx_valid, tx_err, tx_lpi, rx_ready;
  int         n_mismatch = 0, n_compared = 0, n_rxclk = 0, n_rxc = 0, n_txclk = 0, k;
  logic [8:0] txq[$];

  pmac_port pmac_port_inst (.clk_sys, .rstn, .mode_sel, .speed_sel, .full_duplex, .link_up,
    .txd, .tx_en, .tx_er, .gtx_clk, .tx_ctl, .txc, .tx_clk, .txd_hi_pd, .tx_er_pd, .gtx_clk_pd,
    .rxd, .rx_dv, .rx_er, .rx_ctl, .rx_clk, .rxc, .col, .crs, .tx_data, .tx_valid, .tx_err,
    .tx_lpi, .rx_data, .rx_valid, .rx_err, .rx_lpi, .rx_ready, .carrier, .collision);
  pmac_mac_model pmac_mac_model_inst (.tx_clk, .txd, .tx_en, .tx_er, .gtx_clk, .tx_ctl, .txc);

  // Clock, byte capture and link clock counts
  initial
  begin
    forever #25 clk_sys = ~clk_sys;
  end
  always @(negedge clk_sys) if (tx_valid === 1'b1) txq.push_back({tx_err, tx_data});
  always @(posedge rx_clk) n_rxclk++;
  always @(posedge rxc) n_rxc++;
  always @(posedge tx_clk) n_txclk++;

  // ****************************************
  // Helper tasks
  // ****************************************
  task reset_to(input logic [1:0] m, input logic [1:0] s, input int len);
    @(negedge clk_sys) rstn = 0;
    mode_sel = m;
    speed_sel = s;
    repeat (len) @(negedge clk_sys);
    rstn = 1;
    repeat (4) @(negedge clk_sys);
  endtask

  // Offer a byte and hold it until taken
  task offer(input logic [7:0] d, input logic e);
    int i;
    @(negedge clk_sys) rx_data = d;
    rx_valid = 1;
    rx_err = e;
    #1;
    for (i = 0; i < 999 && rx_ready !== 1'b1; i++) @(negedge clk_sys);
    @(negedge clk_sys) rx_valid = 0;
    for (i = 0; i < 99 && rx_dv !== 1'b1 && rx_ctl !== 1'b1; i++) @(negedge clk_sys);
  endtask

  task chk_tx(input logic [8:0] e);
    logic [8:0] g;
    g = txq.size() ? txq.pop_front() : 9'h1FF;
    `CHK(g, e)
  endtask

  task automatic count_rises(ref int n, input int e);
    k = n;
    repeat (80) @(negedge clk_sys);
    `CHK(n - k, e)
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task t_gmii();
    full_duplex = 1;
    reset_to(2'h0, 2'h2, 20);
    `CHK({txd_hi_pd, tx_er_pd, gtx_clk_pd}, 3'b000)
    count_rises(n_rxclk, 10);
    pmac_mac_model_inst.gmii_beat(8'hA5, 1, 0);
    pmac_mac_model_inst.gmii_beat(8'h3C, 1, 1);
    pmac_mac_model_inst.gmii_beat(8'h01, 0, 1);
    pmac_mac_model_inst.release_pins();
    repeat (8) @(negedge clk_sys);
    chk_tx(9'h0A5);
    chk_tx(9'h13C);
    `CHK(tx_lpi, 1'b1)
    offer(8'hC3, 0);
    `CHK({rx_dv, rx_er, rxd}, 10'h2C3)
    offer(8'h5E, 1);
    `CHK({rx_dv, rx_er, rxd}, 10'h35E)
    rx_lpi = 1;
    repeat (20) @(negedge clk_sys);
    `CHK({rx_dv, rx_er, rxd}, 10'h101)
    rx_lpi = 0;
  endtask

  task t_colcrs();
    full_duplex = 0;
    reset_to(2'h0, 2'h2, 3);
    carrier = 1;
    collision = 1;
    repeat (2) @(negedge clk_sys);
    `CHK({col, crs}, 2'b11)
    full_duplex = 1;
    repeat (2) @(negedge clk_sys);
    `CHK({col, crs}, 2'b01)
    carrier = 0;
    collision = 0;
  endtask

  task t_mii();
    reset_to(2'h1, 2'h1, 3);
    `CHK({txd_hi_pd, tx_er_pd, gtx_clk_pd}, 3'b101)
    count_rises(n_txclk, 2);
    pmac_mac_model_inst.mii_byte(8'h7E);
    pmac_mac_model_inst.release_pins();
    repeat (10) @(negedge clk_sys);
    chk_tx(9'h07E);
    offer(8'h5A, 1);
    `CHK({rx_dv, rx_er, rxd}, 10'h30A)
    @(negedge rx_clk);
    @(negedge clk_sys);
    `CHK({rx_dv, rx_er, rxd}, 10'h305)
  endtask

  task t_rgmii();
    link_up = 1;
    reset_to(2'h2, 2'h2, 3);
    `CHK({txd_hi_pd, tx_er_pd, gtx_clk_pd, rx_clk}, 4'b1100)
    count_rises(n_rxc, 10);
    `CHK({rx_ctl, rxd[3:0]}, 5'h0D)
    pmac_mac_model_inst.rgmii_byte(8'h96, 1);
    pmac_mac_model_inst.rgmii_byte(8'h41, 0);
    pmac_mac_model_inst.release_pins();
    repeat (6) @(negedge clk_sys);
    chk_tx(9'h196);
    chk_tx(9'h041);
    offer(8'hB6, 1);
    `CHK({rx_ctl, rxd[3:0]}, 5'h16)
    @(negedge rxc);
    @(negedge clk_sys);
    `CHK({rx_ctl, rxd[3:0]}, 5'h0B)
    rx_lpi = 1;
    @(posedge rxc);
    @(negedge clk_sys);
    `CHK({rx_ctl, rxd[3:0]}, 5'h01)
    @(negedge rxc);
    @(negedge clk_sys);
    `CHK({rx_ctl, rxd[3:0]}, 5'h10)
    rx_lpi = 0;
  endtask

  // ****************************************
  // Run control
  // ****************************************
  task print_verdict();
    $display("Mismatches %0d, comparisons %0d", n_mismatch, n_compared);
    if (n_mismatch == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    t_gmii();
    t_colcrs();
    t_mii();
    t_rgmii();
    print_verdict();
  end

  // Watchdog
  initial
  begin
    #500000;
    n_mismatch++;
    print_verdict();
  end
endmodule // pmac_port_test

`default_nettype wire
